// ### hw/ocds_flag_bank.v
`timescale 1ns/1ps
`include "ocds_consts.vh"

module ocds_flag_bank (
    // Clock and reset
    input wire sys_clk,
    input wire reset,
    // Register port
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    // One-cycle RMS update strobe
    input wire one_cycle_rms_update,
    // Line-to-line voltage conditions
    input wire ac_line_swell,
    input wire bc_line_swell,
    input wire ab_line_swell,
    input wire ac_line_dip,
    input wire bc_line_dip,
    input wire ab_line_dip,
    // Voltage channel sum condition
    input wire voltage_sum_swell,
    // Auxiliary channel conditions, index is channel number
    input wire [5:0] aux_swell,
    input wire [5:0] aux_dip,
    // Phase swell conditions
    input wire phc_current_swell,
    input wire phc_voltage_swell,
    input wire phb_current_swell,
    input wire phb_voltage_swell,
    input wire pha_current_swell,
    input wire pha_voltage_swell,
    // Phase dip conditions
    input wire phc_current_dip,
    input wire phc_voltage_dip,
    input wire phb_current_dip,
    input wire phb_voltage_dip,
    input wire pha_current_dip,
    input wire pha_voltage_dip,
    // Register read data and flag view
    output reg [31:0] reg_rdata,
    output wire [31:0] one_cycle_dip_swell_flags,
    // Interrupt
    output wire irq
);

    wire [31:0] cond;
    wire [31:0] flags;
    wire [31:0] w1c;
    wire [31:0] irq_status;
    wire [31:0] rise;
    wire sel_flags;
    wire sel_stat;
    wire sel_mask;
    wire sel_live;
    wire sel_cnt;
    wire stat_rd_clear;
    reg [31:0] flags_d;
    reg [31:0] irq_mask;
    reg [15:0] upd_cnt;
    reg [31:0] next_rdata;

    // Condition vector assembled in register order
    assign cond[`OCDS_B_RESERVED] = 1'b0;
    assign cond[`OCDS_B_AC_SWELL] = ac_line_swell;
    assign cond[`OCDS_B_BC_SWELL] = bc_line_swell;
    assign cond[`OCDS_B_AB_SWELL] = ab_line_swell;
    assign cond[`OCDS_B_AC_DIP] = ac_line_dip;
    assign cond[`OCDS_B_BC_DIP] = bc_line_dip;
    assign cond[`OCDS_B_AB_DIP] = ab_line_dip;
    assign cond[`OCDS_B_VOLTAGE_CHANNEL_SUM_SWELL] = voltage_sum_swell;
    assign cond[`OCDS_B_AUX_SWELL_LO+5:`OCDS_B_AUX_SWELL_LO] = aux_swell;
    assign cond[`OCDS_B_PHC_I_SWELL] = phc_current_swell;
    assign cond[`OCDS_B_PHC_V_SWELL] = phc_voltage_swell;
    assign cond[`OCDS_B_PHB_I_SWELL] = phb_current_swell;
    assign cond[`OCDS_B_PHB_V_SWELL] = phb_voltage_swell;
    assign cond[`OCDS_B_PHA_I_SWELL] = pha_current_swell;
    assign cond[`OCDS_B_PHA_V_SWELL] = pha_voltage_swell;
    assign cond[`OCDS_B_AUX_DIP_LO+5:`OCDS_B_AUX_DIP_LO] = aux_dip;
    assign cond[`OCDS_B_PHC_I_DIP] = phc_current_dip;
    assign cond[`OCDS_B_PHC_V_DIP] = phc_voltage_dip;
    assign cond[`OCDS_B_PHB_I_DIP] = phb_current_dip;
    assign cond[`OCDS_B_PHB_V_DIP] = phb_voltage_dip;
    assign cond[`OCDS_B_PHA_I_DIP] = pha_current_dip;
    assign cond[`OCDS_B_PHA_V_DIP] = pha_voltage_dip;

    // Address decode
    assign sel_flags = (reg_addr == `OCDS_OFS_FLAGS);
    assign sel_stat = (reg_addr == `OCDS_OFS_IRQ_STAT);
    assign sel_mask = (reg_addr == `OCDS_OFS_IRQ_MASK);
    assign sel_live = (reg_addr == `OCDS_OFS_LIVE);
    assign sel_cnt = (reg_addr == `OCDS_OFS_UPD_CNT);

    // Write-one-to-clear strobes, reserved bit never cleared or set
    assign w1c = (reg_wr && sel_flags) ? (reg_wdata & `OCDS_USED_MASK) : 32'h00000000;

    // Flags only rise at an RMS update, so a cleared flag stays low until then
    // Line-to-line voltage flags
    ocds_flag_cell u_ac_swell (
        .sys_clk(sys_clk), .reset(reset), .update(one_cycle_rms_update),
        .cond(cond[`OCDS_B_AC_SWELL]), .clear(w1c[`OCDS_B_AC_SWELL]),
        .flag(flags[`OCDS_B_AC_SWELL])
    );
    ocds_flag_cell u_bc_swell (
        .sys_clk(sys_clk), .reset(reset), .update(one_cycle_rms_update),
        .cond(cond[`OCDS_B_BC_SWELL]), .clear(w1c[`OCDS_B_BC_SWELL]),
        .flag(flags[`OCDS_B_BC_SWELL])
    );
    ocds_flag_cell u_ab_swell (
        .sys_clk(sys_clk), .reset(reset), .update(one_cycle_rms_update),
        .cond(cond[`OCDS_B_AB_SWELL]), .clear(w1c[`OCDS_B_AB_SWELL]),
        .flag(flags[`OCDS_B_AB_SWELL])
    );
    ocds_flag_cell u_ac_dip (
        .sys_clk(sys_clk), .reset(reset), .update(one_cycle_rms_update),
        .cond(cond[`OCDS_B_AC_DIP]), .clear(w1c[`OCDS_B_AC_DIP]),
        .flag(flags[`OCDS_B_AC_DIP])
    );
    ocds_flag_cell u_bc_dip (
        .sys_clk(sys_clk), .reset(reset), .update(one_cycle_rms_update),
        .cond(cond[`OCDS_B_BC_DIP]), .clear(w1c[`OCDS_B_BC_DIP]),
        .flag(flags[`OCDS_B_BC_DIP])
    );
    ocds_flag_cell u_ab_dip (
        .sys_clk(sys_clk), .reset(reset), .update(one_cycle_rms_update),
        .cond(cond[`OCDS_B_AB_DIP]), .clear(w1c[`OCDS_B_AB_DIP]),
        .flag(flags[`OCDS_B_AB_DIP])
    );

    // Summed voltage and auxiliary swell flags
    ocds_flag_cell u_voltage_channel_sum_swell (
        .sys_clk(sys_clk), .reset(reset), .update(one_cycle_rms_update),
        .cond(cond[`OCDS_B_VOLTAGE_CHANNEL_SUM_SWELL]), .clear(w1c[`OCDS_B_VOLTAGE_CHANNEL_SUM_SWELL]),
        .flag(flags[`OCDS_B_VOLTAGE_CHANNEL_SUM_SWELL])
    );
    ocds_flag_cell u_aux5_swell (
        .sys_clk(sys_clk), .reset(reset), .update(one_cycle_rms_update),
        .cond(cond[`OCDS_B_AUX_SWELL_LO+5]), .clear(w1c[`OCDS_B_AUX_SWELL_LO+5]),
        .flag(flags[`OCDS_B_AUX_SWELL_LO+5])
    );
    ocds_flag_cell u_aux4_swell (
        .sys_clk(sys_clk), .reset(reset), .update(one_cycle_rms_update),
        .cond(cond[`OCDS_B_AUX_SWELL_LO+4]), .clear(w1c[`OCDS_B_AUX_SWELL_LO+4]),
        .flag(flags[`OCDS_B_AUX_SWELL_LO+4])
    );
    ocds_flag_cell u_aux3_swell (
        .sys_clk(sys_clk), .reset(reset), .update(one_cycle_rms_update),
        .cond(cond[`OCDS_B_AUX_SWELL_LO+3]), .clear(w1c[`OCDS_B_AUX_SWELL_LO+3]),
        .flag(flags[`OCDS_B_AUX_SWELL_LO+3])
    );
    ocds_flag_cell u_aux2_swell (
        .sys_clk(sys_clk), .reset(reset), .update(one_cycle_rms_update),
        .cond(cond[`OCDS_B_AUX_SWELL_LO+2]), .clear(w1c[`OCDS_B_AUX_SWELL_LO+2]),
        .flag(flags[`OCDS_B_AUX_SWELL_LO+2])
    );
    ocds_flag_cell u_aux1_swell (
        .sys_clk(sys_clk), .reset(reset), .update(one_cycle_rms_update),
        .cond(cond[`OCDS_B_AUX_SWELL_LO+1]), .clear(w1c[`OCDS_B_AUX_SWELL_LO+1]),
        .flag(flags[`OCDS_B_AUX_SWELL_LO+1])
    );
    ocds_flag_cell u_aux0_swell (
        .sys_clk(sys_clk), .reset(reset), .update(one_cycle_rms_update),
        .cond(cond[`OCDS_B_AUX_SWELL_LO]), .clear(w1c[`OCDS_B_AUX_SWELL_LO]),
        .flag(flags[`OCDS_B_AUX_SWELL_LO])
    );

    // Phase swell flags
    ocds_flag_cell u_phc_i_swell (
        .sys_clk(sys_clk), .reset(reset), .update(one_cycle_rms_update),
        .cond(cond[`OCDS_B_PHC_I_SWELL]), .clear(w1c[`OCDS_B_PHC_I_SWELL]),
        .flag(flags[`OCDS_B_PHC_I_SWELL])
    );
    ocds_flag_cell u_phc_v_swell (
        .sys_clk(sys_clk), .reset(reset), .update(one_cycle_rms_update),
        .cond(cond[`OCDS_B_PHC_V_SWELL]), .clear(w1c[`OCDS_B_PHC_V_SWELL]),
        .flag(flags[`OCDS_B_PHC_V_SWELL])
    );
    ocds_flag_cell u_phb_i_swell (
        .sys_clk(sys_clk), .reset(reset), .update(one_cycle_rms_update),
        .cond(cond[`OCDS_B_PHB_I_SWELL]), .clear(w1c[`OCDS_B_PHB_I_SWELL]),
        .flag(flags[`OCDS_B_PHB_I_SWELL])
    );
    ocds_flag_cell u_phb_v_swell (
        .sys_clk(sys_clk), .reset(reset), .update(one_cycle_rms_update),
        .cond(cond[`OCDS_B_PHB_V_SWELL]), .clear(w1c[`OCDS_B_PHB_V_SWELL]),
        .flag(flags[`OCDS_B_PHB_V_SWELL])
    );
    ocds_flag_cell u_pha_i_swell (
        .sys_clk(sys_clk), .reset(reset), .update(one_cycle_rms_update),
        .cond(cond[`OCDS_B_PHA_I_SWELL]), .clear(w1c[`OCDS_B_PHA_I_SWELL]),
        .flag(flags[`OCDS_B_PHA_I_SWELL])
    );
    ocds_flag_cell u_pha_v_swell (
        .sys_clk(sys_clk), .reset(reset), .update(one_cycle_rms_update),
        .cond(cond[`OCDS_B_PHA_V_SWELL]), .clear(w1c[`OCDS_B_PHA_V_SWELL]),
        .flag(flags[`OCDS_B_PHA_V_SWELL])
    );

    // Auxiliary and phase dip flags
    ocds_flag_cell u_aux5_dip (
        .sys_clk(sys_clk), .reset(reset), .update(one_cycle_rms_update),
        .cond(cond[`OCDS_B_AUX_DIP_LO+5]), .clear(w1c[`OCDS_B_AUX_DIP_LO+5]),
        .flag(flags[`OCDS_B_AUX_DIP_LO+5])
    );
    ocds_flag_cell u_aux4_dip (
        .sys_clk(sys_clk), .reset(reset), .update(one_cycle_rms_update),
        .cond(cond[`OCDS_B_AUX_DIP_LO+4]), .clear(w1c[`OCDS_B_AUX_DIP_LO+4]),
        .flag(flags[`OCDS_B_AUX_DIP_LO+4])
    );
    ocds_flag_cell u_aux3_dip (
        .sys_clk(sys_clk), .reset(reset), .update(one_cycle_rms_update),
        .cond(cond[`OCDS_B_AUX_DIP_LO+3]), .clear(w1c[`OCDS_B_AUX_DIP_LO+3]),
        .flag(flags[`OCDS_B_AUX_DIP_LO+3])
    );
    ocds_flag_cell u_aux2_dip (
        .sys_clk(sys_clk), .reset(reset), .update(one_cycle_rms_update),
        .cond(cond[`OCDS_B_AUX_DIP_LO+2]), .clear(w1c[`OCDS_B_AUX_DIP_LO+2]),
        .flag(flags[`OCDS_B_AUX_DIP_LO+2])
    );
    ocds_flag_cell u_aux1_dip (
        .sys_clk(sys_clk), .reset(reset), .update(one_cycle_rms_update),
        .cond(cond[`OCDS_B_AUX_DIP_LO+1]), .clear(w1c[`OCDS_B_AUX_DIP_LO+1]),
        .flag(flags[`OCDS_B_AUX_DIP_LO+1])
    );
    ocds_flag_cell u_aux0_dip (
        .sys_clk(sys_clk), .reset(reset), .update(one_cycle_rms_update),
        .cond(cond[`OCDS_B_AUX_DIP_LO]), .clear(w1c[`OCDS_B_AUX_DIP_LO]),
        .flag(flags[`OCDS_B_AUX_DIP_LO])
    );
    ocds_flag_cell u_phc_i_dip (
        .sys_clk(sys_clk), .reset(reset), .update(one_cycle_rms_update),
        .cond(cond[`OCDS_B_PHC_I_DIP]), .clear(w1c[`OCDS_B_PHC_I_DIP]),
        .flag(flags[`OCDS_B_PHC_I_DIP])
    );
    ocds_flag_cell u_phc_v_dip (
        .sys_clk(sys_clk), .reset(reset), .update(one_cycle_rms_update),
        .cond(cond[`OCDS_B_PHC_V_DIP]), .clear(w1c[`OCDS_B_PHC_V_DIP]),
        .flag(flags[`OCDS_B_PHC_V_DIP])
    );
    ocds_flag_cell u_phb_i_dip (
        .sys_clk(sys_clk), .reset(reset), .update(one_cycle_rms_update),
        .cond(cond[`OCDS_B_PHB_I_DIP]), .clear(w1c[`OCDS_B_PHB_I_DIP]),
        .flag(flags[`OCDS_B_PHB_I_DIP])
    );
    ocds_flag_cell u_phb_v_dip (
        .sys_clk(sys_clk), .reset(reset), .update(one_cycle_rms_update),
        .cond(cond[`OCDS_B_PHB_V_DIP]), .clear(w1c[`OCDS_B_PHB_V_DIP]),
        .flag(flags[`OCDS_B_PHB_V_DIP])
    );
    ocds_flag_cell u_pha_i_dip (
        .sys_clk(sys_clk), .reset(reset), .update(one_cycle_rms_update),
        .cond(cond[`OCDS_B_PHA_I_DIP]), .clear(w1c[`OCDS_B_PHA_I_DIP]),
        .flag(flags[`OCDS_B_PHA_I_DIP])
    );
    ocds_flag_cell u_pha_v_dip (
        .sys_clk(sys_clk), .reset(reset), .update(one_cycle_rms_update),
        .cond(cond[`OCDS_B_PHA_V_DIP]), .clear(w1c[`OCDS_B_PHA_V_DIP]),
        .flag(flags[`OCDS_B_PHA_V_DIP])
    );

    assign flags[`OCDS_B_RESERVED] = 1'b0;
    assign one_cycle_dip_swell_flags = flags;

    // Flag rise detection feeds the sticky interrupt status
    always @(posedge sys_clk) begin
        if (reset) begin
            flags_d <= `OCDS_FLAGS_RST;
        end else begin
            flags_d <= flags;
        end
    end

    assign rise = flags & ~flags_d;

    assign stat_rd_clear = reg_rd && sel_stat;

    ocds_irq_unit #(
        .WIDTH(32)
    ) u_irq (
        .sys_clk(sys_clk),
        .reset(reset),
        .event_set(rise),
        .rd_clear(stat_rd_clear),
        .mask(irq_mask),
        .status(irq_status),
        .irq(irq)
    );

    // Mask register and update counter
    always @(posedge sys_clk) begin
        if (reset) begin
            irq_mask <= `OCDS_IRQ_MASK_RST;
        end else if (reg_wr && sel_mask) begin
            irq_mask <= reg_wdata & `OCDS_USED_MASK;
        end
    end

    // Counter wraps; software compares two reads to see fresh RMS results
    always @(posedge sys_clk) begin
        if (reset) begin
            upd_cnt <= `OCDS_UPD_CNT_RST;
        end else if (one_cycle_rms_update) begin
            upd_cnt <= upd_cnt + 16'h0001;
        end
    end

    // Read mux, unmapped offsets read zero
    always @* begin
        next_rdata = 32'h00000000;
        if (sel_flags) begin
            next_rdata = flags;
        end else if (sel_stat) begin
            next_rdata = irq_status;
        end else if (sel_mask) begin
            next_rdata = irq_mask;
        end else if (sel_live) begin
            next_rdata = cond;
        end else if (sel_cnt) begin
            next_rdata = {16'h0000, upd_cnt};
        end
    end

    // Data stands only in the cycle after the read strobe
    always @(posedge sys_clk) begin
        if (reset) begin
            reg_rdata <= `OCDS_RDATA_RST;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end

endmodule // ocds_flag_bank

// ### hw/ocds_consts.vh
`ifndef OCDS_CONSTS_VH
`define OCDS_CONSTS_VH

// Register byte offsets
`define OCDS_OFS_FLAGS 8'h00
`define OCDS_OFS_IRQ_STAT 8'h04
`define OCDS_OFS_IRQ_MASK 8'h08
`define OCDS_OFS_LIVE 8'h0C
`define OCDS_OFS_UPD_CNT 8'h10

// Reset values
`define OCDS_FLAGS_RST 32'h00000000
`define OCDS_IRQ_STAT_RST 32'h00000000
`define OCDS_IRQ_MASK_RST 32'h00000000
`define OCDS_UPD_CNT_RST 16'h0000
`define OCDS_RDATA_RST 32'h00000000

// Implemented flag bits; bit 31 is reserved
`define OCDS_USED_MASK 32'h7FFFFFFF
`define OCDS_B_RESERVED 31

// Flag bit positions
`define OCDS_B_AC_SWELL 30
`define OCDS_B_BC_SWELL 29
`define OCDS_B_AB_SWELL 28
`define OCDS_B_AC_DIP 27
`define OCDS_B_BC_DIP 26
`define OCDS_B_AB_DIP 25
`define OCDS_B_VOLTAGE_CHANNEL_SUM_SWELL 24
`define OCDS_B_AUX_SWELL_LO 18
`define OCDS_B_PHC_I_SWELL 17
`define OCDS_B_PHC_V_SWELL 16
`define OCDS_B_PHB_I_SWELL 15
`define OCDS_B_PHB_V_SWELL 14
`define OCDS_B_PHA_I_SWELL 13
`define OCDS_B_PHA_V_SWELL 12
`define OCDS_B_AUX_DIP_LO 6
`define OCDS_B_PHC_I_DIP 5
`define OCDS_B_PHC_V_DIP 4
`define OCDS_B_PHB_I_DIP 3
`define OCDS_B_PHB_V_DIP 2
`define OCDS_B_PHA_I_DIP 1
`define OCDS_B_PHA_V_DIP 0

`endif

// ### hw/ocds_flag_cell.v
`timescale 1ns/1ps
module ocds_flag_cell (
    // Clock and reset
    input wire sys_clk,
    input wire reset,
    // Condition side
    input wire update,
    input wire cond,
    // Software side
    input wire clear,
    // Flag
    output reg flag
);

    // An update that still sees the condition wins over a clear in the same cycle
    always @(posedge sys_clk) begin
        if (reset) begin
            flag <= 1'b0;
        end else if (update) begin
            flag <= cond;
        end else if (clear) begin
            flag <= 1'b0;
        end
    end

endmodule // ocds_flag_cell

// ### hw/ocds_irq_unit.v
`timescale 1ns/1ps
module ocds_irq_unit #(
    parameter WIDTH = 32
) (
    // Clock and reset
    input wire sys_clk,
    input wire reset,
    // Events and control
    input wire [WIDTH-1:0] event_set,
    input wire rd_clear,
    input wire [WIDTH-1:0] mask,
    // Status and interrupt
    output reg [WIDTH-1:0] status,
    output wire irq
);

    // Set wins over the read clear so that no event is lost
    always @(posedge sys_clk) begin
        if (reset) begin
            status <= {WIDTH{1'b0}};
        end else if (rd_clear) begin
            status <= event_set;
        end else begin
            status <= status | event_set;
        end
    end

    assign irq = |(status & mask);

endmodule // ocds_irq_unit

// ### dv/ocds_flag_bank_props.sv
`timescale 1ns/1ps
module ocds_flag_bank_props (
    // Clock and reset
    input wire sys_clk,
    input wire reset,
    // Register port
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire [31:0] reg_rdata,
    // Flag view
    input wire [31:0] one_cycle_dip_swell_flags,
    // Conditions
    input wire one_cycle_rms_update,
    input wire ac_line_swell,
    input wire bc_line_swell,
    input wire ab_line_swell,
    input wire ac_line_dip,
    input wire bc_line_dip,
    input wire ab_line_dip,
    input wire voltage_sum_swell,
    input wire [5:0] aux_swell,
    input wire [5:0] aux_dip,
    input wire phc_current_swell,
    input wire phc_voltage_swell,
    input wire phb_current_swell,
    input wire phb_voltage_swell,
    input wire pha_current_swell,
    input wire pha_voltage_swell,
    input wire phc_current_dip,
    input wire phc_voltage_dip,
    input wire phb_current_dip,
    input wire phb_voltage_dip,
    input wire pha_current_dip,
    input wire pha_voltage_dip
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    wire [31:0] f = one_cycle_dip_swell_flags;
    wire u = one_cycle_rms_update;
    wire wr0 = reg_wr && reg_addr == 8'h00;
    wire [31:0] c = {1'b0, ac_line_swell, bc_line_swell, ab_line_swell, ac_line_dip,
        bc_line_dip, ab_line_dip, voltage_sum_swell, aux_swell, phc_current_swell,
        phc_voltage_swell, phb_current_swell, phb_voltage_swell, pha_current_swell,
        pha_voltage_swell, aux_dip, phc_current_dip, phc_voltage_dip, phb_current_dip,
        phb_voltage_dip, pha_current_dip, pha_voltage_dip};
    property p_line_swell; u |=> f[30:28] == $past(c[30:28]); endproperty
    a_line_swell: assert property (p_line_swell) else $error("line swell flag");
    property p_line_dip; u |=> f[27:25] == $past(c[27:25]); endproperty
    a_line_dip: assert property (p_line_dip) else $error("line dip flag");
    property p_voltage_channel_sum; u |=> f[24] == $past(c[24]); endproperty
    a_voltage_channel_sum: assert property (p_voltage_channel_sum) else $error("sum swell flag");
    property p_aux_swell; u |=> f[23:18] == $past(c[23:18]); endproperty
    a_aux_swell: assert property (p_aux_swell) else $error("aux swell flag");
    property p_aux_dip; u |=> f[11:6] == $past(c[11:6]); endproperty
    a_aux_dip: assert property (p_aux_dip) else $error("aux dip flag");
    property p_ph_v; u |=> {f[16], f[14], f[12]} == $past({c[16], c[14], c[12]}); endproperty
    a_ph_v: assert property (p_ph_v) else $error("phase voltage swell");
    property p_ph_i; u |=> {f[17], f[15], f[13]} == $past({c[17], c[15], c[13]}); endproperty
    a_ph_i: assert property (p_ph_i) else $error("phase current swell");
    property p_ph_dip; u |=> f[5:0] == $past(c[5:0]); endproperty
    a_ph_dip: assert property (p_ph_dip) else $error("phase dip flag");
    property p_res; f[31] == 1'b0; endproperty
    a_res: assert property (p_res) else $error("reserved bit set");
    property p_hold; !u && !wr0 |=> $stable(f); endproperty
    a_hold: assert property (p_hold) else $error("flags moved");
    property p_w1c; wr0 && !u |=> (f & $past(reg_wdata)) == 32'h0; endproperty
    a_w1c: assert property (p_w1c) else $error("flag not cleared");
    property p_rd; reg_rd && reg_addr == 8'h00 |=> reg_rdata == $past(f); endproperty
    a_rd: assert property (p_rd) else $error("flag read");
    cover property (u && c != 32'h0);
    cover property (u && wr0);
    cover property (wr0);
    cover property (reg_rd && reg_addr == 8'h04);
endmodule // ocds_flag_bank_props

bind ocds_flag_bank ocds_flag_bank_props u_props (.*);

// ### dv/ocds_flag_bank_tb.sv
`timescale 1ns/1ps
module ocds_flag_bank_tb;
    logic sys_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, upd_p = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, flags;
    logic [30:0] cv = 31'h0;
    logic irq;
    int err_count = 0, checked = 0;
    always #2 sys_clk = ~sys_clk;
    ocds_flag_bank dut (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .one_cycle_rms_update(upd_p),
        .ac_line_swell(cv[30]), .bc_line_swell(cv[29]), .ab_line_swell(cv[28]),
        .ac_line_dip(cv[27]), .bc_line_dip(cv[26]), .ab_line_dip(cv[25]),
        .voltage_sum_swell(cv[24]), .aux_swell(cv[23:18]), .aux_dip(cv[11:6]),
        .phc_current_swell(cv[17]), .phc_voltage_swell(cv[16]), .phb_current_swell(cv[15]),
        .phb_voltage_swell(cv[14]), .pha_current_swell(cv[13]), .pha_voltage_swell(cv[12]),
        .phc_current_dip(cv[5]), .phc_voltage_dip(cv[4]), .phb_current_dip(cv[3]),
        .phb_voltage_dip(cv[2]), .pha_current_dip(cv[1]), .pha_voltage_dip(cv[0]),
        .reg_rdata(reg_rdata), .one_cycle_dip_swell_flags(flags), .irq(irq));
    task chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, e);
    endtask
    task upd(input logic [30:0] c);
        @(posedge sys_clk);
        cv <= c;
        upd_p <= 1'b1;
        @(posedge sys_clk);
        upd_p <= 1'b0;
        #1;
    endtask
    task chk_irq(input logic e);
        checked++;
        if (irq !== e) begin
            err_count++;
            $display("unexpected at %0t: irq %b want %b", $time, irq, e);
        end
    endtask
    // Write-one-to-clear and RMS update land on the same edge
    task wr_upd(input logic [31:0] d, input logic [30:0] c);
        @(posedge sys_clk);
        reg_addr <= 8'h00;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        cv <= c;
        upd_p <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        upd_p <= 1'b0;
        #1;
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_count++;
        test_done;
    end
    initial begin
        repeat (4) @(posedge sys_clk);
        reset <= 1'b0;
        rd(8'h00, 32'h0);
        // Read data stands for one cycle only, then returns to zero
        @(posedge sys_clk);
        #1;
        chk(reg_rdata, 32'h0);
        rd(8'h08, 32'h0);
        chk_irq(1'b0);
        $display("test reset done");
        for (int i = 0; i < 31; i++) begin
            upd(31'h1 << i);
            chk(flags, 32'h1 << i);
        end
        upd(31'h7FFFFFFF);
        rd(8'h0C, 32'h7FFFFFFF);
        rd(8'h10, 32'h00000020);
        wr(8'h10, 32'h0000FFFF);
        wr(8'h0C, 32'h00000000);
        rd(8'h10, 32'h00000020);
        rd(8'h0C, 32'h7FFFFFFF);
        rd(8'h00, 32'h7FFFFFFF);
        wr(8'h00, 32'h0000FFFF);
        rd(8'h00, 32'h7FFF0000);
        wr(8'h00, 32'hFFFFFFFF);
        chk(flags, 32'h0);
        upd(31'h7FFFFFFF);
        chk(flags, 32'h7FFFFFFF);
        upd(31'h0);
        chk(flags, 32'h0);
        wr_upd(32'hFFFFFFFF, 31'h00000401);
        chk(flags, 32'h00000401);
        wr(8'h00, 32'hFFFFFFFF);
        chk(flags, 32'h0);
        rd(8'h40, 32'h0);
        $display("test clear done");
        // Every bit rose during the walk, so all events are pending
        rd(8'h04, 32'h7FFFFFFF);
        wr(8'h08, 32'h20000000);
        rd(8'h08, 32'h20000000);
        upd(31'h20000001);
        @(posedge sys_clk);
        #1;
        chk_irq(1'b1);
        rd(8'h04, 32'h20000001);
        chk_irq(1'b0);
        upd(31'h0);
        wr(8'h08, 32'h0);
        upd(31'h20000000);
        @(posedge sys_clk);
        #1;
        chk_irq(1'b0);
        $display("test interrupt done");
        test_done;
    end
endmodule // ocds_flag_bank_tb
